// ### logic/pmib_mask_bank.sv
// Interrupt mask bank: mask registers, raw status paths and sticky flags
module pmib_mask_bank (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register access port from the serial interface
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  // Register-reset mask value from OTP
  input wire logic otp_reg_reset_mask,
  // Raw status levels from analog monitors (asynchronous)
  input wire logic global_pg_src,
  input wire logic sync_clk_invalid_src,
  input wire logic thermal_warn_src,
  input wire logic sw1_pg_invalid_src,
  input wire logic sw0_pg_invalid_src,
  input wire logic sw1_curlim_src,
  input wire logic sw0_curlim_src,
  // One-cycle events from internal logic on sys_clk
  input wire logic meas_done_evt,
  input wire logic reg_reset_evt,
  // Flag clears from the flag register block
  input wire logic global_pg_irq_clr,
  input wire logic sync_clk_irq_clr,
  input wire logic thermal_warn_irq_clr,
  input wire logic meas_ready_irq_clr,
  input wire logic reg_reset_irq_clr,
  input wire logic sw1_pg_irq_clr,
  input wire logic sw0_pg_irq_clr,
  input wire logic sw1_curlim_irq_clr,
  input wire logic sw0_curlim_irq_clr,
  // Raw status outputs
  output logic global_pg_raw_status,
  output logic sync_clk_raw_status,
  output logic thermal_warn_raw_status,
  output logic sw1_pg_raw_status,
  output logic sw0_pg_raw_status,
  output logic sw1_curlim_raw_status,
  output logic sw0_curlim_raw_status,
  // Sticky interrupt flags
  output logic global_pg_irq_flag,
  output logic sync_clk_irq_flag,
  output logic thermal_warn_irq_flag,
  output logic meas_ready_irq_flag,
  output logic reg_reset_irq_flag,
  output logic sw1_pg_irq_flag,
  output logic sw0_pg_irq_flag,
  output logic sw1_curlim_irq_flag,
  output logic sw0_curlim_irq_flag,
  // Mask register contents
  output logic [7:0] sys_mask_a,
  output logic [7:0] sys_mask_b,
  output logic [7:0] buck_mask
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0] sys_mask_a_q;
  logic [6:0] sys_mask_b_hi_q;
  logic reg_reset_mask_q;
  logic otp_load_q;
  logic [7:0] buck_mask_q;
  logic [6:0] raw_sync;
  logic [6:0] raw_prev_q;
  logic [6:0] rise;
  logic [6:0] fall;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic hit_d;
  // Per-register write strobes
  logic wr_sys_a;
  logic wr_sys_b;
  logic wr_buck;
  // Qualified set strobes, one per flag
  logic set_global_pg;
  logic set_sync_clk;
  logic set_thermal;
  logic set_meas;
  logic set_reg_reset;
  logic set_sw1_pg;
  logic set_sw0_pg;
  logic set_sw1_curlim;
  logic set_sw0_curlim;

  // Bit positions in the synchronised raw vector
  localparam int IDX_GLOBAL_PG = 6;
  localparam int IDX_SYNC_CLK = 5;
  localparam int IDX_THERMAL = 4;
  localparam int IDX_SW1_PG = 3;
  localparam int IDX_SW0_PG = 2;
  localparam int IDX_SW1_CURLIM = 1;
  localparam int IDX_SW0_CURLIM = 0;

  // Rising edge of a raw level against its previous sample
  function automatic logic [6:0] edge_up(input logic [6:0] now, input logic [6:0] was);
    edge_up = now & ~was;
  endfunction

  // Write strobe aimed at one register address
  function automatic logic wr_to(input logic wr, input logic [7:0] addr, input logic [7:0] target);
    wr_to = wr && (addr == target);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write decode

  // One strobe per mapped register; other addresses write nothing
  assign wr_sys_a = wr_to(reg_wr, reg_addr, pmib_pkg::ADDR_SYS_MASK_A);
  assign wr_sys_b = wr_to(reg_wr, reg_addr, pmib_pkg::ADDR_SYS_MASK_B);
  assign wr_buck = wr_to(reg_wr, reg_addr, pmib_pkg::ADDR_BUCK_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // Mask registers

  // System mask A: all eight bits read and write
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sys_mask_a_q <= pmib_pkg::RST_SYS_MASK_A;
    end else if (wr_sys_a) begin
      sys_mask_a_q <= reg_wdata;
    end
  end

  // System mask B upper bits: plain storage
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sys_mask_b_hi_q <= pmib_pkg::RST_SYS_MASK_B_HI;
    end else if (wr_sys_b) begin
      sys_mask_b_hi_q <= reg_wdata[7:1];
    end
  end

  // Marks the first cycle after reset release for the OTP load
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      otp_load_q <= 1'b1;
    end else begin
      otp_load_q <= 1'b0;
    end
  end

  // Register-reset mask: reloaded from OTP after every reset
  // A host write on the load edge loses to the OTP value
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_reset_mask_q <= 1'b1;
    end else if (otp_load_q) begin
      reg_reset_mask_q <= otp_reg_reset_mask;
    end else if (wr_sys_b) begin
      reg_reset_mask_q <= reg_wdata[pmib_pkg::BIT_REG_RESET];
    end
  end

  // Buck mask: reserved bits never stored
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      buck_mask_q <= pmib_pkg::RST_BUCK_MASK;
    end else if (wr_buck) begin
      buck_mask_q <= reg_wdata & pmib_pkg::BUCK_MASK_WR;
    end
  end

  assign sys_mask_a = sys_mask_a_q;
  assign sys_mask_b = {sys_mask_b_hi_q, reg_reset_mask_q};
  assign buck_mask = buck_mask_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  // Address decode for reads
  // Hit follows the address with no clock
  always_comb begin
    rdata_d = 8'h00;
    hit_d = 1'b1;
    case (reg_addr)
      pmib_pkg::ADDR_SYS_MASK_A: rdata_d = sys_mask_a_q;
      pmib_pkg::ADDR_SYS_MASK_B: rdata_d = {sys_mask_b_hi_q, reg_reset_mask_q};
      pmib_pkg::ADDR_BUCK_MASK: rdata_d = buck_mask_q & pmib_pkg::BUCK_MASK_WR;
      default: hit_d = 1'b0;
    endcase
  end

  // Registered read data, held between reads
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_hit = hit_d;

  ////////////////////////////////////////////////////////////////////////////
  // Raw status path

  // Order: 6 global pg, 5 sync, 4 thermal, 3 sw1 pg, 2 sw0 pg, 1 sw1 ilim, 0 sw0 ilim
  pmib_sync #(
    .WIDTH(7)
  ) u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .async_in({global_pg_src, sync_clk_invalid_src, thermal_warn_src, sw1_pg_invalid_src,
               sw0_pg_invalid_src, sw1_curlim_src, sw0_curlim_src}),
    .level_out(raw_sync)
  );

  // Raw status never depends on any mask
  // Levels reach these outputs four edges after the pin moves
  assign global_pg_raw_status = raw_sync[IDX_GLOBAL_PG];
  assign sync_clk_raw_status = raw_sync[IDX_SYNC_CLK];
  assign thermal_warn_raw_status = raw_sync[IDX_THERMAL];
  assign sw1_pg_raw_status = raw_sync[IDX_SW1_PG];
  assign sw0_pg_raw_status = raw_sync[IDX_SW0_PG];
  assign sw1_curlim_raw_status = raw_sync[IDX_SW1_CURLIM];
  assign sw0_curlim_raw_status = raw_sync[IDX_SW0_CURLIM];

  // Previous raw levels for edge detection
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      raw_prev_q <= 7'h00;
    end else begin
      raw_prev_q <= raw_sync;
    end
  end

  // Rise means becoming invalid or active, fall means becoming valid
  assign rise = edge_up(raw_sync, raw_prev_q);
  assign fall = edge_up(raw_prev_q, raw_sync);

  ////////////////////////////////////////////////////////////////////////////
  // Event qualification; masked events are dropped, not remembered

  // System events: global power-good on any change, others on assertion
  assign set_global_pg = (rise[IDX_GLOBAL_PG] | fall[IDX_GLOBAL_PG]) &
                         ~sys_mask_a_q[pmib_pkg::BIT_GLOBAL_PG];
  assign set_sync_clk = rise[IDX_SYNC_CLK] & ~sys_mask_a_q[pmib_pkg::BIT_SYNC_CLK];
  assign set_thermal = rise[IDX_THERMAL] & ~sys_mask_a_q[pmib_pkg::BIT_THERMAL];
  assign set_meas = meas_done_evt & ~sys_mask_a_q[pmib_pkg::BIT_MEAS];

  // Register-reset event against the OTP-loaded mask
  assign set_reg_reset = reg_reset_evt & ~reg_reset_mask_q;

  // Buck power-good: invalid edge uses the fall mask, valid edge the rise mask
  // Raw power-good is high while the output is invalid
  assign set_sw1_pg = (rise[IDX_SW1_PG] & ~buck_mask_q[pmib_pkg::BIT_SW1_FALL]) |
                      (fall[IDX_SW1_PG] & ~buck_mask_q[pmib_pkg::BIT_SW1_RISE]);
  assign set_sw0_pg = (rise[IDX_SW0_PG] & ~buck_mask_q[pmib_pkg::BIT_SW0_FALL]) |
                      (fall[IDX_SW0_PG] & ~buck_mask_q[pmib_pkg::BIT_SW0_RISE]);

  // Buck current limit on assertion only
  assign set_sw1_curlim = rise[IDX_SW1_CURLIM] & ~buck_mask_q[pmib_pkg::BIT_SW1_CURLIM];
  assign set_sw0_curlim = rise[IDX_SW0_CURLIM] & ~buck_mask_q[pmib_pkg::BIT_SW0_CURLIM];

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags; a mask change never touches a latched flag

  // Global power-good flag
  pmib_flag u_global_pg (
    .sys_clk(sys_clk),
    .srst(srst),
    .set_evt(set_global_pg),
    .clr(global_pg_irq_clr),
    .flag_q(global_pg_irq_flag)
  );

  // Sync clock detection flag
  pmib_flag u_sync_clk (
    .sys_clk(sys_clk),
    .srst(srst),
    .set_evt(set_sync_clk),
    .clr(sync_clk_irq_clr),
    .flag_q(sync_clk_irq_flag)
  );

  // Thermal warning flag
  pmib_flag u_thermal (
    .sys_clk(sys_clk),
    .srst(srst),
    .set_evt(set_thermal),
    .clr(thermal_warn_irq_clr),
    .flag_q(thermal_warn_irq_flag)
  );

  // Measurement ready flag
  pmib_flag u_meas (
    .sys_clk(sys_clk),
    .srst(srst),
    .set_evt(set_meas),
    .clr(meas_ready_irq_clr),
    .flag_q(meas_ready_irq_flag)
  );

  // Register-reset flag
  pmib_flag u_reg_reset (
    .sys_clk(sys_clk),
    .srst(srst),
    .set_evt(set_reg_reset),
    .clr(reg_reset_irq_clr),
    .flag_q(reg_reset_irq_flag)
  );

  // Buck 1 power-good: invalid and valid directions share one flag
  pmib_flag u_sw1_pg (
    .sys_clk(sys_clk),
    .srst(srst),
    .set_evt(set_sw1_pg),
    .clr(sw1_pg_irq_clr),
    .flag_q(sw1_pg_irq_flag)
  );

  // Buck 0 power-good: invalid and valid directions share one flag
  pmib_flag u_sw0_pg (
    .sys_clk(sys_clk),
    .srst(srst),
    .set_evt(set_sw0_pg),
    .clr(sw0_pg_irq_clr),
    .flag_q(sw0_pg_irq_flag)
  );

  // Buck 1 current-limit flag
  pmib_flag u_sw1_curlim (
    .sys_clk(sys_clk),
    .srst(srst),
    .set_evt(set_sw1_curlim),
    .clr(sw1_curlim_irq_clr),
    .flag_q(sw1_curlim_irq_flag)
  );

  // Buck 0 current-limit flag
  pmib_flag u_sw0_curlim (
    .sys_clk(sys_clk),
    .srst(srst),
    .set_evt(set_sw0_curlim),
    .clr(sw0_curlim_irq_clr),
    .flag_q(sw0_curlim_irq_flag)
  );

endmodule

// ### pkg/pmib_pkg.sv
// Package of offsets, field positions and reset values for the interrupt mask bank
// Summary of operation
// - Bit 7 of system mask A masks the global power-good flag; resets to 1.
// - Raw power-good status keeps tracking its source whatever the mask says.
// - Bit 4 of system mask A masks the sync clock detection flag; resets to 1.
// - Sync clock validity status is never touched by its mask.
// - Bit 2 of system mask A masks the thermal warning flag; resets to 0.
// - Raw thermal warning status is independent of its mask.
// - Bit 0 of system mask A masks the measurement ready flag; resets to 0.
// - Bit 0 of system mask B masks the register-reset flag.
// - Register-reset mask comes from OTP at reset; host writes change it until the next reset.
// - Buck mask bit 7 masks buck 1 power-good-invalid events.
// - Buck mask bit 6, reset 1, masks buck 1 power-good-valid events, same flag.
// - Each buck raw power-good status ignores its direction masks.
// - Buck mask bit 4, reset 0, masks the buck 1 current-limit flag.
// - Buck mask bit 3, reset 1, masks buck 0 power-good-invalid events.
// - Buck mask bit 2, reset 1, masks buck 0 power-good-valid events.
// - Buck mask bit 0, reset 0, masks the buck 0 current-limit flag.
// - Each buck raw current-limit status ignores its current-limit mask.
// - Buck raw power-good reads 0 when output valid, 1 when invalid.
package pmib_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_SYS_MASK_A = 8'h20;
  localparam logic [7:0] ADDR_SYS_MASK_B = 8'h21;
  localparam logic [7:0] ADDR_BUCK_MASK = 8'h22;
  // Field positions, system mask A
  localparam int BIT_GLOBAL_PG = 7;
  localparam int BIT_SYNC_CLK = 4;
  localparam int BIT_THERMAL = 2;
  localparam int BIT_MEAS = 0;
  // Field positions, system mask B
  localparam int BIT_REG_RESET = 0;
  // Field positions, buck mask
  localparam int BIT_SW1_FALL = 7;
  localparam int BIT_SW1_RISE = 6;
  localparam int BIT_SW1_CURLIM = 4;
  localparam int BIT_SW0_FALL = 3;
  localparam int BIT_SW0_RISE = 2;
  localparam int BIT_SW0_CURLIM = 0;
  // Reset values
  localparam logic [7:0] RST_SYS_MASK_A = 8'h90;
  localparam logic [6:0] RST_SYS_MASK_B_HI = 7'h00;
  localparam logic [7:0] RST_BUCK_MASK = 8'hCC;
  // Writable bits of the buck mask
  localparam logic [7:0] BUCK_MASK_WR = 8'hDD;
  // Synchroniser depth for pin-level status inputs
  localparam int SYNC_STAGES = 3;
endpackage

// ### logic/pmib_sync.sv
// Three-stage synchroniser with agreement filter for pin-level inputs
module pmib_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Asynchronous levels in, filtered levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] st1_q;
  logic [WIDTH-1:0] st2_q;
  logic [WIDTH-1:0] st3_q;

  // Shift chain; first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st1_q <= '0;
      st2_q <= '0;
      st3_q <= '0;
    end else begin
      st1_q <= async_in;
      st2_q <= st1_q;
      st3_q <= st2_q;
    end
  end

  // Accept a bit only once stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      level_out <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (st2_q[i] == st3_q[i]) begin
          level_out[i] <= st3_q[i];
        end
      end
    end
  end
endmodule

// ### logic/pmib_flag.sv
// Sticky interrupt flag with set-over-clear priority
module pmib_flag (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Qualified event and clear
  input wire logic set_evt,
  input wire logic clr,
  // Latched flag
  output logic flag_q
);
  // Set wins over clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flag_q <= 1'b0;
    end else if (set_evt) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end
  end
endmodule

// ### tb/pmib_mask_bank_properties.sv
// Concurrent checks on the mask bank ports
module pmib_mask_bank_properties (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  input wire logic otp_reg_reset_mask,
  // Events, clear and flags
  input wire logic meas_done_evt,
  input wire logic reg_reset_evt,
  input wire logic meas_ready_irq_clr,
  input wire logic meas_ready_irq_flag,
  input wire logic reg_reset_irq_flag,
  // Mask contents
  input wire logic [7:0] sys_mask_a,
  input wire logic [7:0] sys_mask_b,
  input wire logic [7:0] buck_mask
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  // Reset values and register behaviour
  AST_RST_VAL: assert property ($fell(srst) |-> sys_mask_a == 8'h90 && buck_mask == 8'hCC)
    else $error("mask reset value wrong");
  AST_OTP_LOAD: assert property ($fell(srst) |=> sys_mask_b[0] == $past(otp_reg_reset_mask))
    else $error("otp mask not loaded");
  AST_BUCK_WR: assert property (reg_wr && reg_addr == 8'h22 |=> buck_mask == ($past(reg_wdata) & 8'hDD))
    else $error("buck mask write wrong");
  AST_BUCK_RSV: assert property (buck_mask[5] == 1'b0 && buck_mask[1] == 1'b0)
    else $error("buck reserved bit set");
  AST_RD_BUCK: assert property (reg_rd && reg_addr == 8'h22 |=> reg_rdata == $past(buck_mask))
    else $error("buck read wrong");
  AST_UNMAP_RD: assert property (reg_rd && !reg_hit |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_HIT: assert property (reg_hit == (reg_addr == 8'h20 || reg_addr == 8'h21 || reg_addr == 8'h22))
    else $error("address hit wrong");
  AST_SYSA_WR: assert property (reg_wr && reg_addr == 8'h20 |=> sys_mask_a == $past(reg_wdata))
    else $error("mask a write wrong");
  // Flag qualification
  AST_MEAS_SET: assert property (meas_done_evt && !sys_mask_a[0] |=> meas_ready_irq_flag)
    else $error("meas flag not set");
  AST_MEAS_BLOCK: assert property (meas_done_evt && sys_mask_a[0] && !meas_ready_irq_flag |=> !meas_ready_irq_flag)
    else $error("masked meas flag set");
  AST_STICKY: assert property (meas_ready_irq_flag && !meas_ready_irq_clr |=> meas_ready_irq_flag)
    else $error("flag lost without clear");
  AST_REGRST_SET: assert property (reg_reset_evt && !sys_mask_b[0] |=> reg_reset_irq_flag)
    else $error("reg reset flag not set");
  // Main scenarios
  COV_MEAS: cover property (meas_done_evt && !sys_mask_a[0]);
  COV_UNMAP: cover property (reg_rd && !reg_hit);
  COV_BUCK_WR: cover property (reg_wr && reg_addr == 8'h22);
endmodule
bind pmib_mask_bank pmib_mask_bank_properties u_props (.sys_clk, .srst, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata, .reg_hit, .otp_reg_reset_mask, .meas_done_evt, .reg_reset_evt,
  .meas_ready_irq_clr, .meas_ready_irq_flag, .reg_reset_irq_flag, .sys_mask_a, .sys_mask_b, .buck_mask);

// ### tb/pmib_host_model.sv
// Host model driving the register port
module pmib_host_model (
  // Clock
  input wire logic sys_clk,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle port at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // One write; released lines show inverted values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // One read; data taken after the capture edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

// ### tb/pmib_mask_bank_tb.sv
// Self-checking bench for the interrupt mask bank
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module pmib_mask_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic otp_reg_reset_mask = 1'b0;
  logic meas_done_evt = 1'b0;
  logic reg_reset_evt = 1'b0;
  logic [6:0] src = 7'h00;
  logic [8:0] clr = 9'h000;
  logic [6:0] raw;
  logic [8:0] flags;
  logic reg_wr, reg_rd, reg_hit;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, sys_mask_a, sys_mask_b, buck_mask, rdv;
  int err_total = 0;
  int n_tests = 0;
  // Design, host and clock
  pmib_mask_bank u_dut (.sys_clk, .srst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit,
    .otp_reg_reset_mask, .meas_done_evt, .reg_reset_evt, .sys_mask_a, .sys_mask_b, .buck_mask,
    .global_pg_src(src[6]), .sync_clk_invalid_src(src[5]), .thermal_warn_src(src[4]),
    .sw1_pg_invalid_src(src[3]), .sw0_pg_invalid_src(src[2]), .sw1_curlim_src(src[1]), .sw0_curlim_src(src[0]),
    .global_pg_irq_clr(clr[8]), .sync_clk_irq_clr(clr[7]), .thermal_warn_irq_clr(clr[6]),
    .meas_ready_irq_clr(clr[5]), .reg_reset_irq_clr(clr[4]), .sw1_pg_irq_clr(clr[3]),
    .sw0_pg_irq_clr(clr[2]), .sw1_curlim_irq_clr(clr[1]), .sw0_curlim_irq_clr(clr[0]),
    .global_pg_raw_status(raw[6]), .sync_clk_raw_status(raw[5]), .thermal_warn_raw_status(raw[4]),
    .sw1_pg_raw_status(raw[3]), .sw0_pg_raw_status(raw[2]), .sw1_curlim_raw_status(raw[1]),
    .sw0_curlim_raw_status(raw[0]), .global_pg_irq_flag(flags[8]), .sync_clk_irq_flag(flags[7]),
    .thermal_warn_irq_flag(flags[6]), .meas_ready_irq_flag(flags[5]), .reg_reset_irq_flag(flags[4]),
    .sw1_pg_irq_flag(flags[3]), .sw0_pg_irq_flag(flags[2]), .sw1_curlim_irq_flag(flags[1]),
    .sw0_curlim_irq_flag(flags[0]));
  pmib_host_model u_host (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
  always #4 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  // Read and compare
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, rdv);
    `CHK(rdv, e)
  endtask
  // Reset with a given OTP mask value
  task automatic do_rst(input logic o);
    @(posedge sys_clk);
    srst <= 1'b1;
    otp_reg_reset_mask <= o;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  // Pulse both internal events
  task automatic pulse;
    @(posedge sys_clk);
    meas_done_evt <= 1'b1;
    reg_reset_evt <= 1'b1;
    @(posedge sys_clk);
    meas_done_evt <= 1'b0;
    reg_reset_evt <= 1'b0;
    #1;
  endtask
  // Clear every flag
  task automatic clear;
    @(posedge sys_clk);
    clr <= 9'h1FF;
    @(posedge sys_clk);
    clr <= 9'h000;
  endtask
  // Move sources, then check raw levels and flags
  task automatic ev(input logic [6:0] s, input logic [8:0] e);
    @(posedge sys_clk);
    src <= s;
    repeat (8) @(posedge sys_clk);
    #1;
    `CHK(raw, s)
    `CHK(flags, e)
    clear();
  endtask
  // Verdict
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    do_rst(1'b0);
    rc(8'h20, 8'h90);
    rc(8'h21, 8'h00);
    rc(8'h22, 8'hCC);
    rc(8'h30, 8'h00);
    u_host.wr(8'h22, 8'hFF);
    rc(8'h22, 8'hDD);
    u_host.wr(8'h21, 8'h01);
    rc(8'h21, 8'h01);
    do_rst(1'b0);
    rc(8'h21, 8'h00);
    rc(8'h22, 8'hCC);
    do_rst(1'b1);
    rc(8'h21, 8'h01);
    $display("test registers done");
    u_host.wr(8'h20, 8'h00);
    u_host.wr(8'h21, 8'h00);
    pulse();
    `CHK(flags, 9'h030)
    u_host.wr(8'h20, 8'h01);
    #1;
    `CHK(flags, 9'h030)
    clear();
    u_host.wr(8'h21, 8'h01);
    pulse();
    `CHK(flags, 9'h000)
    u_host.wr(8'h20, 8'hFF);
    u_host.wr(8'h22, 8'hFF);
    ev(7'h7F, 9'h000);
    ev(7'h00, 9'h000);
    u_host.wr(8'h20, 8'h00);
    u_host.wr(8'h22, 8'h00);
    ev(7'h7F, 9'h1CF);
    ev(7'h00, 9'h10C);
    u_host.wr(8'h20, 8'h80);
    u_host.wr(8'h22, 8'h44);
    ev(7'h0C, 9'h00C);
    ev(7'h00, 9'h000);
    u_host.wr(8'h22, 8'h88);
    ev(7'h0C, 9'h000);
    ev(7'h00, 9'h00C);
    $display("test events done");
    results();
  end
  // Watchdog
  initial begin
    repeat (3000) @(posedge sys_clk);
    err_total++;
    results();
  end
endmodule
